/* File: trap_and_vector_unit.sv */
// trap and vector selection unit with axi4-lite register slave
// How it works
// - hardware traps unmaskable, branch to fixed vector
// - each hardware trap except reset sets its own flag bit
// - hardware trap preempts only a running trap of lower class
// - no interrupt during hardware trap service
// - reset sources vector 0, number 0, class III
// - class A: nmi, stack over/underflow vectors
// - class B share vector 28h, number 0Ah
// - software trap any number, current cpu priority
// - each source own flags, vector four times number
// - sixteen levels; only higher level interrupts
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`include "trap_map.svh"
module trap_and_vector_unit (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic nmi_pin_n,
  input wire logic sw_reset,
  input wire logic wdt_overflow,
  input wire logic stack_overflow,
  input wire logic stack_underflow,
  input wire trap_pkg::class_b_t class_b_fault,
  input wire logic swtrap_req,
  input wire logic [6:0] swtrap_num,
  input wire logic [3:0] cpu_level,
  input wire logic [`NUM_SRC-1:0] periph_req,
  output logic take_valid,
  output trap_pkg::take_t take,
  input wire logic take_ack,
  input wire logic trap_done,
  output logic irq
);
  function automatic logic [23:0] vec_of(input logic [6:0] num);
    vec_of = {15'h0000, num, 2'b00};
  endfunction
  function automatic logic src_hit(input logic [11:0] a);
    src_hit = (a >= `OFF_SRC_BASE) && (a[1:0] == 2'b00) &&
      (a < `OFF_SRC_BASE + 12'(4 * `NUM_SRC));
  endfunction
  function automatic logic [5:0] src_idx(input logic [11:0] a);
    logic [11:0] d;
    d = a - `OFF_SRC_BASE;
    src_idx = d[7:2];
  endfunction

  // axi group
  logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
  logic [11:0] wa_r, wa_nxt;
  logic [31:0] wd_r, wd_nxt;
  logic wb0_r, wb0_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wr_do;
  // trap group
  logic nmi_s1_r, nmi_s2_r, nmi_s3_r;
  trap_pkg::trap_flag_t flags_r, flags_nxt;
  trap_pkg::state_t state_r, state_nxt;
  trap_pkg::kind_t kind_r, kind_nxt;
  trap_pkg::take_t take_r, take_nxt;
  logic reset_pend_r, reset_pend_nxt, nmi_pend_r, nmi_pend_nxt;
  logic ovf_pend_r, ovf_pend_nxt, unf_pend_r, unf_pend_nxt;
  logic clsb_pend_r, clsb_pend_nxt, sw_pend_r, sw_pend_nxt;
  logic [6:0] sw_num_r, sw_num_nxt;
  logic [1:0] trap_cls_r, trap_cls_nxt;
  logic [5:0] per_idx_r, per_idx_nxt;
  logic [3:0] stat_r, stat_nxt, en_r, en_nxt;
  logic irq_r, irq_nxt;
  logic [7:0] ctl_r [`NUM_SRC];
  logic [7:0] ctl_nxt [`NUM_SRC];
  logic found;
  logic [5:0] best_idx;
  logic [3:0] best_lvl;

  assign wr_do = aw_full_r && w_full_r && !bvalid_r;

  always_comb begin
    aw_full_nxt = aw_full_r;
    w_full_nxt = w_full_r;
    wa_nxt = wa_r;
    wd_nxt = wd_r;
    wb0_nxt = wb0_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (awvalid && !aw_full_r) begin
      aw_full_nxt = 1'b1;
      wa_nxt = awaddr;
    end
    if (wvalid && !w_full_r) begin
      w_full_nxt = 1'b1;
      wd_nxt = wdata;
      wb0_nxt = wstrb[0];
    end
    if (wr_do) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = `RESP_OKAY;
      if (!src_hit(wa_r) && wa_r != `OFF_FLAGS && wa_r != `OFF_IRQ_EN &&
          wa_r != `OFF_IRQ_CLR)
        bresp_nxt = `RESP_SLVERR;
    end
    if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
      aw_full_nxt = 1'b0;
      w_full_nxt = 1'b0;
    end
    // one read in flight: arready drops until the data is taken
    arready_nxt = !rvalid_nxt && !(arvalid && arready_r);
    if (arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = `RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      if (src_hit(araddr))
        rdata_nxt[7:0] = ctl_r[src_idx(araddr)];
      else if (araddr == `OFF_FLAGS)
        rdata_nxt[7:0] = flags_r;
      else if (araddr == `OFF_IRQ_STAT)
        rdata_nxt[3:0] = stat_r;
      else if (araddr == `OFF_IRQ_EN)
        rdata_nxt[3:0] = en_r;
      else if (araddr == `OFF_STATE)
        rdata_nxt[3:0] = {trap_cls_r, take_r.hw, state_r == trap_pkg::S_OFFER};
      else if (araddr != `OFF_IRQ_CLR)
        rresp_nxt = `RESP_SLVERR;
    end else if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      wa_r <= 12'h000;
      wd_r <= 32'h0000_0000;
      wb0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= `RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      wa_r <= wa_nxt;
      wd_r <= wd_nxt;
      wb0_r <= wb0_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // nmi pin is asynchronous: three flops, edge taken from the last two stages
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nmi_s1_r <= 1'b1;
      nmi_s2_r <= 1'b1;
      nmi_s3_r <= 1'b1;
    end else begin
      nmi_s1_r <= nmi_pin_n;
      nmi_s2_r <= nmi_s1_r;
      nmi_s3_r <= nmi_s2_r;
    end
  end

  always_comb begin
    trap_pkg::trap_flag_t fset;
    logic [3:0] ev;
    logic wr_ok;
    fset = '0;
    ev = 4'h0;
    wr_ok = wr_do && wb0_r;
    reset_pend_nxt = reset_pend_r || sw_reset || wdt_overflow;
    nmi_pend_nxt = nmi_pend_r || (nmi_s3_r && !nmi_s2_r);
    ovf_pend_nxt = ovf_pend_r || stack_overflow;
    unf_pend_nxt = unf_pend_r || stack_underflow;
    clsb_pend_nxt = clsb_pend_r || (|class_b_fault);
    sw_pend_nxt = sw_pend_r;
    sw_num_nxt = sw_num_r;
    if (swtrap_req && !sw_pend_r) begin
      sw_pend_nxt = 1'b1;
      sw_num_nxt = swtrap_num;
    end
    fset.nmi = nmi_s3_r && !nmi_s2_r;
    fset.stk_ovf = stack_overflow;
    fset.stk_unf = stack_underflow;
    fset.cls_b = class_b_fault;
    flags_nxt = flags_r;
    if (wr_ok && wa_r == `OFF_FLAGS)
      flags_nxt = flags_nxt & ~wd_r[7:0];
    flags_nxt = flags_nxt | fset;
    for (int i = 0; i < `NUM_SRC; i++) begin
      ctl_nxt[i] = ctl_r[i];
      if (wr_ok && src_hit(wa_r) && src_idx(wa_r) == 6'(i))
        ctl_nxt[i] = wd_r[7:0];
    end
    // highest level above the cpu level wins, lowest index on a tie
    found = 1'b0;
    best_idx = 6'h00;
    best_lvl = 4'h0;
    for (int i = 0; i < `NUM_SRC; i++) begin
      if (ctl_r[i][`CTL_IR_BIT] && ctl_r[i][`CTL_IE_BIT] &&
          ctl_r[i][`CTL_LVL_MSB:0] > cpu_level &&
          (!found || ctl_r[i][`CTL_LVL_MSB:0] > best_lvl)) begin
        found = 1'b1;
        best_idx = 6'(i);
        best_lvl = ctl_r[i][`CTL_LVL_MSB:0];
      end
    end
    state_nxt = state_r;
    kind_nxt = kind_r;
    take_nxt = take_r;
    per_idx_nxt = per_idx_r;
    trap_cls_nxt = trap_cls_r;
    if (trap_done)
      trap_cls_nxt = `CLS_NONE;
    case (state_r)
      trap_pkg::S_IDLE: begin
        state_nxt = trap_pkg::S_OFFER;
        take_nxt.hw = 1'b1;
        // classes ranked, no mask applies
        if (reset_pend_r && trap_cls_r < `CLS_III) begin
          kind_nxt = trap_pkg::K_RESET;
          take_nxt.num = `NUM_RESET;
          take_nxt.cls = `CLS_III;
        end else if (nmi_pend_r && trap_cls_r < `CLS_II) begin
          kind_nxt = trap_pkg::K_NMI;
          take_nxt.num = `NUM_NMI;
          take_nxt.cls = `CLS_II;
        end else if (ovf_pend_r && trap_cls_r < `CLS_II) begin
          kind_nxt = trap_pkg::K_STK_OVF;
          take_nxt.num = `NUM_STK_OVF;
          take_nxt.cls = `CLS_II;
        end else if (unf_pend_r && trap_cls_r < `CLS_II) begin
          kind_nxt = trap_pkg::K_STK_UNF;
          take_nxt.num = `NUM_STK_UNF;
          take_nxt.cls = `CLS_II;
        end else if (clsb_pend_r && trap_cls_r < `CLS_I) begin
          kind_nxt = trap_pkg::K_CLSB;
          take_nxt.num = `NUM_CLASS_B;
          take_nxt.cls = `CLS_I;
        end else if (sw_pend_r) begin
          kind_nxt = trap_pkg::K_SW;
          take_nxt.num = sw_num_r;
          take_nxt.cls = `CLS_NONE;
          take_nxt.hw = 1'b0;
        end else if (found && trap_cls_r == `CLS_NONE) begin
          kind_nxt = trap_pkg::K_PER;
          per_idx_nxt = best_idx;
          take_nxt.num = `SRC_FIRST_NUM + {1'b0, best_idx};
          take_nxt.cls = `CLS_NONE;
          take_nxt.hw = 1'b0;
        end else begin
          state_nxt = trap_pkg::S_IDLE;
        end
        take_nxt.vec = vec_of(take_nxt.num);
      end
      trap_pkg::S_OFFER: begin
        if (take_ack) begin
          state_nxt = trap_pkg::S_IDLE;
          if (take_r.hw)
            trap_cls_nxt = take_r.cls;
          case (kind_r)
            trap_pkg::K_RESET: begin
              reset_pend_nxt = sw_reset || wdt_overflow;
              ev[`EV_RESET] = 1'b1;
            end
            trap_pkg::K_NMI: nmi_pend_nxt = fset.nmi;
            trap_pkg::K_STK_OVF: ovf_pend_nxt = stack_overflow;
            trap_pkg::K_STK_UNF: unf_pend_nxt = stack_underflow;
            trap_pkg::K_CLSB: clsb_pend_nxt = |class_b_fault;
            trap_pkg::K_SW: begin
              sw_pend_nxt = swtrap_req;
              sw_num_nxt = swtrap_num;
              ev[`EV_SW_TRAP] = 1'b1;
            end
            default: begin
              ctl_nxt[per_idx_r][`CTL_IR_BIT] = 1'b0;
              ev[`EV_PERIPH] = 1'b1;
            end
          endcase
          ev[`EV_HW_TRAP] = take_r.hw && take_r.cls != `CLS_III;
        end
      end
      default: state_nxt = trap_pkg::S_IDLE;
    endcase
    // a request arriving with a clear of its flag still sets it
    for (int i = 0; i < `NUM_SRC; i++) begin
      if (periph_req[i])
        ctl_nxt[i][`CTL_IR_BIT] = 1'b1;
    end
    en_nxt = en_r;
    if (wr_ok && wa_r == `OFF_IRQ_EN)
      en_nxt = wd_r[3:0];
    stat_nxt = stat_r;
    if (wr_ok && wa_r == `OFF_IRQ_CLR)
      stat_nxt = stat_nxt & ~wd_r[3:0];
    stat_nxt = stat_nxt | ev;
    irq_nxt = |(stat_nxt & en_nxt);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flags_r <= '0;
      state_r <= trap_pkg::S_IDLE;
      kind_r <= trap_pkg::K_RESET;
      take_r <= '0;
      // leaving reset behaves like a hardware reset trap to vector 0
      reset_pend_r <= 1'b1;
      nmi_pend_r <= 1'b0;
      ovf_pend_r <= 1'b0;
      unf_pend_r <= 1'b0;
      clsb_pend_r <= 1'b0;
      sw_pend_r <= 1'b0;
      sw_num_r <= 7'h00;
      trap_cls_r <= `CLS_NONE;
      per_idx_r <= 6'h00;
      stat_r <= 4'h0;
      en_r <= `IRQ_EN_RESET;
      irq_r <= 1'b0;
      for (int i = 0; i < `NUM_SRC; i++)
        ctl_r[i] <= `CTL_RESET;
    end else begin
      flags_r <= flags_nxt;
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      take_r <= take_nxt;
      reset_pend_r <= reset_pend_nxt;
      nmi_pend_r <= nmi_pend_nxt;
      ovf_pend_r <= ovf_pend_nxt;
      unf_pend_r <= unf_pend_nxt;
      clsb_pend_r <= clsb_pend_nxt;
      sw_pend_r <= sw_pend_nxt;
      sw_num_r <= sw_num_nxt;
      trap_cls_r <= trap_cls_nxt;
      per_idx_r <= per_idx_nxt;
      stat_r <= stat_nxt;
      en_r <= en_nxt;
      irq_r <= irq_nxt;
      for (int i = 0; i < `NUM_SRC; i++)
        ctl_r[i] <= ctl_nxt[i];
    end
  end

  assign awready = !aw_full_r;
  assign wready = !w_full_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;
  assign take_valid = state_r == trap_pkg::S_OFFER;
  assign take = take_r;
  assign irq = irq_r;
endmodule

/* File: trap_map.svh */
// offsets, field positions, codes and reset values of the trap unit
`ifndef TRAP_MAP_SVH
`define TRAP_MAP_SVH
`define OFF_FLAGS 12'h000
`define OFF_IRQ_STAT 12'h004
`define OFF_IRQ_EN 12'h008
`define OFF_IRQ_CLR 12'h00C
`define OFF_STATE 12'h010
`define OFF_SRC_BASE 12'h100
`define NUM_SRC 56
`define SRC_FIRST_NUM 7'h10
`define CTL_LVL_MSB 3
`define CTL_IE_BIT 6
`define CTL_IR_BIT 7
`define CTL_RESET 8'h00
`define IRQ_EN_RESET 4'h0
`define EV_HW_TRAP 0
`define EV_RESET 1
`define EV_SW_TRAP 2
`define EV_PERIPH 3
`define NUM_RESET 7'h00
`define NUM_NMI 7'h02
`define NUM_STK_OVF 7'h04
`define NUM_STK_UNF 7'h06
`define NUM_CLASS_B 7'h0A
`define CLS_NONE 2'h0
`define CLS_I 2'h1
`define CLS_II 2'h2
`define CLS_III 2'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* File: trap_pkg.sv */
// types shared by the trap and vector unit
package trap_pkg;
  typedef struct packed {
    logic undef_opc;
    logic prot_fault;
    logic ill_operand;
    logic ill_instr;
    logic ill_bus;
  } class_b_t;
  typedef struct packed {
    logic nmi;
    logic stk_ovf;
    logic stk_unf;
    class_b_t cls_b;
  } trap_flag_t;
  typedef struct packed {
    logic [23:0] vec;
    logic [6:0] num;
    logic hw;
    logic [1:0] cls;
  } take_t;
  typedef enum logic [0:0] {S_IDLE, S_OFFER} state_t;
  typedef enum logic [2:0] {
    K_RESET, K_NMI, K_STK_OVF, K_STK_UNF, K_CLSB, K_SW, K_PER
  } kind_t;
endpackage

/* File: tvu_sva.sv */
// checker for the trap and vector unit ports
module tvu_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic take_valid,
  input wire trap_pkg::take_t take,
  input wire logic take_ack,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  ofr_vec_a: assert property (
    take_valid |-> take.vec == {15'h0, take.num, 2'h0})
    else $error("vector is not four times the number");
  ofr_hold_a: assert property (
    take_valid && !take_ack |=> take_valid && $stable(take))
    else $error("offer changed before ack");
  ofr_drop_a: assert property (
    take_valid && take_ack |=> !take_valid)
    else $error("offer stays after ack");
  rst_vec_a: assert property (
    take_valid && take.cls == 2'h3 |-> take.num == 7'h00 && take.hw)
    else $error("class III offer is not the reset vector");
  cls_a_a: assert property (
    take_valid && take.cls == 2'h2 |->
    take.hw && take.num inside {7'h02, 7'h04, 7'h06})
    else $error("bad class II trap number");
  cls_b_a: assert property (
    take_valid && take.hw && take.cls == 2'h1 |-> take.num == 7'h0A)
    else $error("class I trap not on shared vector");
  rst_offer_a: assert property (
    $rose(rstn) |-> ##[1:2] (take_valid && take.cls == 2'h3))
    else $error("no reset trap after reset");
  rd_resp_a: assert property (
    arvalid && arready |=> rvalid)
    else $error("read answer late");
  cover property (take_valid && take_ack && take.hw);
  cover property (take_valid && take_ack && !take.hw);
  cover property ($rose(irq));
endmodule
bind trap_and_vector_unit tvu_chk chk (.clk, .rstn, .arvalid, .arready,
  .rvalid, .take_valid, .take, .take_ack, .irq);

/* File: cpu_model.sv */
// core model: acks vector offers and ends trap services
module cpu_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic take_valid,
  input wire trap_pkg::take_t take,
  input wire logic [3:0] ack_wait,
  input wire logic hold_svc,
  output logic take_ack,
  output logic trap_done
);
  logic [3:0] cnt_r;
  logic svc_r;
  // one service level only; hold_svc keeps a routine running
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {cnt_r, svc_r, take_ack, trap_done} <= 7'h00;
    end else begin
      take_ack <= 1'b0;
      trap_done <= 1'b0;
      if (take_valid && !take_ack) begin
        cnt_r <= cnt_r + 4'h1;
        if (cnt_r >= ack_wait) begin
          take_ack <= 1'b1;
          cnt_r <= 4'h0;
          svc_r <= svc_r | take.hw;
        end
      end else if (svc_r && !hold_svc) begin
        trap_done <= 1'b1;
        svc_r <= 1'b0;
      end
    end
  end
endmodule

/* File: trap_and_vector_unit_bench.sv */
// self-checking bench for the trap and vector unit
module trap_and_vector_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, awready, awvalid, wready, wvalid, bvalid, bready;
  logic arready, arvalid, rvalid, rready, irq, nmi_pin_n, sw_reset;
  logic wdt_overflow, stack_overflow, stack_underflow, swtrap_req;
  logic take_valid, take_ack, trap_done, hold_svc;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb, cpu_level, ack_wait, lvl;
  logic [1:0] bresp, rresp;
  logic [6:0] swtrap_num;
  logic [55:0] periph_req;
  logic [15:0] rnd;
  trap_pkg::class_b_t class_b_fault;
  trap_pkg::take_t take;
  int failures, cmp_count, cyc, i, idx;
  trap_and_vector_unit dut (.clk, .rstn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .nmi_pin_n,
    .sw_reset, .wdt_overflow, .stack_overflow, .stack_underflow,
    .class_b_fault, .swtrap_req, .swtrap_num, .cpu_level, .periph_req,
    .take_valid, .take, .take_ack, .trap_done, .irq);
  cpu_model core (.clk, .rstn, .take_valid, .take, .ack_wait, .hold_svc,
    .take_ack, .trap_done);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic trap_pkg::take_t exp_t(logic [6:0] n, logic h,
      logic [1:0] c);
    return '{vec: {15'h0, n, 2'h0}, num: n, hw: h, cls: c};
  endfunction
  // expected offer of trigger k: 0..4 class B, 5..7 class A, 8 watchdog
  function automatic trap_pkg::take_t ek(int k);
    case (k)
      5: return exp_t(7'h06, 1'b1, 2'h2);
      6: return exp_t(7'h04, 1'b1, 2'h2);
      7: return exp_t(7'h02, 1'b1, 2'h2);
      8: return exp_t(7'h00, 1'b1, 2'h3);
      default: return exp_t(7'h0A, 1'b1, 2'h1);
    endcase
  endfunction
  task automatic chk(logic [63:0] g, logic [63:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // address and data may be taken at different edges
  task automatic axw(logic [11:0] a, logic [31:0] d, logic [1:0] er);
    logic ta, tw, da, dw;
    {da, dw} = 2'h0;
    @(posedge clk);
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid, bready} <= 3'h7;
    while (!(da && dw)) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      da |= ta;
      dw |= tw;
    end
    do @(negedge clk); while (!bvalid);
    chk(bresp, er);
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic axr(logic [11:0] a, logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do @(negedge clk); while (!arready);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (!rvalid);
    rd = rdata;
    chk(rresp, er);
    @(posedge clk);
    rready <= 1'b0;
  endtask
  // class is left unchecked for offers without a trap class
  task automatic take_chk(trap_pkg::take_t e, logic full);
    do @(negedge clk); while (!(take_valid && take_ack));
    if (full) chk(take, e);
    else chk(take[33:2], e[33:2]);
  endtask
  task automatic quiet(int n);
    repeat (n) begin
      @(negedge clk);
      chk(take_valid, 1'b0);
    end
  endtask
  // nmi pin stays low until the next trigger
  task automatic trig(int k);
    @(posedge clk);
    class_b_fault <= (k < 5) ? 5'(1 << k) : 5'h00;
    {stack_underflow, stack_overflow} <= {k == 5, k == 6};
    {nmi_pin_n, wdt_overflow} <= {k != 7, k == 8};
    @(posedge clk);
    class_b_fault <= 5'h00;
    {stack_underflow, stack_overflow, wdt_overflow} <= 3'h0;
  endtask
  task automatic sw(logic [6:0] n);
    @(posedge clk);
    {swtrap_req, swtrap_num} <= {1'b1, n};
    @(posedge clk);
    swtrap_req <= 1'b0;
    take_chk(exp_t(n, 1'b0, 2'h0), 0);
    repeat (3) @(negedge clk);
  endtask
  initial begin
    {rstn, awvalid, wvalid, bready, arvalid, rready, sw_reset} = 7'h00;
    {wdt_overflow, stack_overflow, stack_underflow, swtrap_req} = 4'h0;
    {hold_svc, awaddr, araddr, wdata, swtrap_num} = 64'h0;
    {cpu_level, ack_wait, periph_req, class_b_fault} = 69'h0;
    {nmi_pin_n, wstrb, rnd} = 21'h1F_0043;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    take_chk(exp_t(7'h00, 1'b1, 2'h3), 1);
    axr(12'h008, 2'h0);
    chk(rd, 32'h0);
    axw(12'h000, 32'hFF, 2'h0);
    for (i = 0; i < 9; i++) begin
      trig(i);
      take_chk(ek(i), 1);
      axr(12'h000, 2'h0);
      chk(rd[7:0], (i < 8) ? 8'(1 << i) : 8'h00);
      axw(12'h000, 32'hFF, 2'h0);
    end
    $display("trap vectors and flags done");
    @(posedge clk);
    {sw_reset, stack_overflow, class_b_fault} <= 7'h70;
    @(posedge clk);
    {sw_reset, stack_overflow, class_b_fault} <= 7'h00;
    take_chk(ek(8), 1);
    take_chk(ek(6), 1);
    take_chk(ek(4), 1);
    @(posedge clk);
    hold_svc <= 1'b1;
    trig(0);
    take_chk(ek(0), 1);
    trig(6);
    take_chk(ek(6), 1);
    axw(12'h100, 32'h4F, 2'h0);
    @(posedge clk);
    periph_req <= 56'h1;
    trig(5);
    periph_req <= 56'h0;
    quiet(12);
    axr(12'h010, 2'h0);
    chk(rd, 32'hA);
    @(posedge clk);
    hold_svc <= 1'b0;
    take_chk(ek(5), 1);
    take_chk(exp_t(7'h10, 1'b0, 2'h0), 0);
    axr(12'h100, 2'h0);
    chk(rd, 32'h4F);
    $display("priority and blocking done");
    for (i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      idx = (i == 0) ? 55 : rnd % 56;
      lvl = 4'h1 + 4'(rnd[15:8] % 15);
      axw(12'(256 + 4 * idx), {24'h0, 4'h4, lvl}, 2'h0);
      @(posedge clk);
      {cpu_level, ack_wait} <= {lvl, 2'h0, rnd[1:0]};
      periph_req <= 56'h1 << idx;
      @(posedge clk);
      periph_req <= 56'h0;
      quiet(6);
      @(posedge clk);
      cpu_level <= lvl - 4'h1;
      take_chk(exp_t(7'(16 + idx), 1'b0, 2'h0), 0);
    end
    $display("peripheral sources done");
    axw(12'h008, 32'h4, 2'h0);
    for (i = 0; i < 5; i++) begin
      rnd = lfsr(rnd);
      sw((i == 0) ? 7'h7F : (i == 1) ? 7'h00 : rnd[6:0]);
      chk(irq, 1'b1);
      axw(12'h00C, 32'hF, 2'h0);
      repeat (2) @(negedge clk);
      chk(irq, 1'b0);
    end
    axw(12'h008, 32'h0, 2'h0);
    sw(7'h55);
    chk(irq, 1'b0);
    axr(12'h004, 2'h0);
    chk(rd, 32'h4);
    axr(12'h020, 2'h2);
    chk(rd, 32'h0);
    axw(12'h004, 32'hF, 2'h2);
    // a write with its low strobe off leaves the register alone
    @(posedge clk);
    wstrb <= 4'h0;
    axw(12'h008, 32'hF, 2'h0);
    wstrb <= 4'hF;
    axr(12'h008, 2'h0);
    chk(rd, 32'h0);
    $display("software traps and irq done");
    finish_test();
  end
endmodule
